// *** rtl/tmr_map.svh ***
/*
  Register offsets, field positions and reset values of the timer block.
  Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
*/
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH
`define OFF_PIE 12'h000
`define OFF_CTRL 12'h004
`define OFF_TLO 12'h008
`define OFF_THI 12'h00c
`define OFF_CCLO 12'h010
`define OFF_CCHI 12'h014
`define OFF_CCCTL 12'h018
`define OFF_STAT 12'h01c
`define OFF_MASK 12'h020
`define OFF_CORE 12'h024
`define PIE_IMPL 8'h7f
`define PIE_OVF 0
`define PIE_CC 2
`define CTRL_RUN 0
`define CTRL_ASYNC 1
`define CTRL_GATE_EN 2
`define CTRL_CSYNC 3
`define CORE_GIE 1
`define CORE_PERIPHERAL_IRQ_GATE 0
`define CC_MODE_LSB 0
`define CC_MODE_MSB 1
`define ST_OVF 0
`define ST_CC 1
`define ST_WAKE 2
`define ST_W 3
`define T_MAX 16'hffff
`define T_ZERO 16'h0000
`define RESP_OK 2'b00
`define RESP_ERR 2'b10
`endif

// *** rtl/tmr_pkg.sv ***
/*
  Types shared by the timer block.
  Assumes the map header is included alongside.
*/
package tmr_pkg;
  typedef enum logic [1:0] {
    CC_OFF = 2'b00,
    CC_CAPTURE = 2'b01,
    CC_COMPARE = 2'b10,
    CC_SPECIAL = 2'b11
  } cc_mode_t;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WRESP = 3'b010,
    BUS_RRESP = 3'b100
  } bus_state_t;
endpackage

// *** rtl/timer_overflow_event.sv ***
/*
  16-bit timer with overflow flag, interrupt gating, sleep wake-up and
  capture/compare time base, reached over AXI4-Lite.
  Assumes inputs synchronous to clk_sys_i; the external count tick and
  capture event are single-cycle strobes from surrounding logic.
*/
// Notes on behaviour
// - Count to FFFFh, wrap to zero, flag
// - Overflow irq needs enable, peripheral, global, or mask bit 0 for irq_o
// - Flag stays set until software clears
// - Sleep counting only in asynchronous mode
// - Overflow in sleep wakes when enabled
// - Wake with global enable vectors after
// - Capture/compare uses the timer as base
// - Capture copies timer into capture pair
// - Compare match raises compare event
// - Special trigger clears timer pair
// - Special clear never sets overflow flag
// - Software write beats special trigger
// - Comparator gate synchronised to timer tick
// - Overflow enable is enable register bit 0
// - Peripheral gate blocks periph_irq_o, not the status mask path to irq_o
// - Enable bit 7 zero, reset to zero
`timescale 1ns/1ps
`include "tmr_map.svh"
module timer_overflow_event
  import tmr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_tick_i,
  input wire logic sleep_i,
  input wire logic comp_out_i,
  input wire logic capture_event_i,
  output logic irq_o,
  output logic periph_irq_o,
  output logic wake_o,
  output logic vector_req_o
);
  logic [7:0] peripheral_irq_enable_one;
  logic [3:0] second_timer_control;
  logic [1:0] core_irq_control;
  logic [1:0] cc_mode;
  logic [15:0] count;
  logic [15:0] capcmp;
  logic [`ST_W-1:0] status;
  logic [`ST_W-1:0] mask;
  logic comp_sync;
  logic wake_pend;
  bus_state_t bus_state;
  logic [11:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;

  // Write channel capture: address and data in either order
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_held || aw_take;
  wire w_have = w_held || w_take;
  wire [11:0] wa = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_held ? w_data : s_axi_wdata;
  wire [3:0] ws = w_held ? w_strb : s_axi_wstrb;
  wire wr_go = (bus_state == BUS_IDLE) && aw_have && w_have;
  wire rd_go = (bus_state == BUS_IDLE) && s_axi_arvalid && !wr_go;
  wire b0 = ws[0];
  wire b1 = ws[1];

  wire wr_pie = wr_go && b0 && (wa == `OFF_PIE);
  wire wr_ctrl = wr_go && b0 && (wa == `OFF_CTRL);
  wire wr_tlo = wr_go && b0 && (wa == `OFF_TLO);
  wire wr_thi = wr_go && b0 && (wa == `OFF_THI);
  wire wr_cclo = wr_go && b0 && (wa == `OFF_CCLO);
  wire wr_cchi = wr_go && b0 && (wa == `OFF_CCHI);
  wire wr_ccctl = wr_go && b0 && (wa == `OFF_CCCTL);
  wire wr_stat = wr_go && b0 && (wa == `OFF_STAT);
  wire wr_mask = wr_go && b0 && (wa == `OFF_MASK);
  wire wr_core = wr_go && b0 && (wa == `OFF_CORE);
  wire wr_hit;
  assign wr_hit = (wa == `OFF_PIE) || (wa == `OFF_CTRL) ||
    (wa == `OFF_TLO) || (wa == `OFF_THI) || (wa == `OFF_CCLO) ||
    (wa == `OFF_CCHI) || (wa == `OFF_CCCTL) || (wa == `OFF_STAT) ||
    (wa == `OFF_MASK) || (wa == `OFF_CORE);
  wire unused_b1 = b1;

  // Timer qualification
  wire run = second_timer_control[`CTRL_RUN];
  wire async_mode = second_timer_control[`CTRL_ASYNC];
  wire gate_en = second_timer_control[`CTRL_GATE_EN];
  wire csync = second_timer_control[`CTRL_CSYNC];
  // Sync keeps a gate edge from splitting a tick
  wire gate_lvl = csync ? comp_sync : comp_out_i;
  wire gate_ok = !gate_en || gate_lvl;
  // Synchronous mode has no clock in sleep
  wire sleep_ok = !sleep_i || async_mode;
  wire tick = run && ext_tick_i && gate_ok && sleep_ok;
  wire wrap = tick && (count == `T_MAX);
  wire [15:0] count_inc = count + 16'h0001;

  // Capture/compare on the timer base
  wire is_cap = (cc_mode == CC_CAPTURE);
  wire is_cmp = (cc_mode == CC_COMPARE) || (cc_mode == CC_SPECIAL);
  wire cap_hit = is_cap && capture_event_i;
  wire cmp_hit = is_cmp && (capcmp == count);
  // Asynchronous timer may skip this match
  wire special = cmp_hit && (cc_mode == CC_SPECIAL);
  wire sw_tw = wr_tlo || wr_thi;

  logic [15:0] next_count;
  always_comb begin
    next_count = count;
    if (wr_tlo) begin
      next_count[7:0] = wd[7:0];
    end else if (wr_thi) begin
      next_count[15:8] = wd[7:0];
    end else if (special) begin
      next_count = `T_ZERO;
    end else if (tick) begin
      next_count = wrap ? `T_ZERO : count_inc;
    end
  end

  logic [15:0] next_capcmp;
  always_comb begin
    next_capcmp = capcmp;
    if (cap_hit) begin
      next_capcmp = count;
    end else if (wr_cclo) begin
      next_capcmp[7:0] = wd[7:0];
    end else if (wr_cchi) begin
      next_capcmp[15:8] = wd[7:0];
    end
  end

  // Only a true wrap sets the overflow flag, never a special clear
  wire ovf_ev = wrap && !sw_tw && !special;
  wire cc_ev = cap_hit || cmp_hit;
  wire oe = peripheral_irq_enable_one[`PIE_OVF];
  wire pe = core_irq_control[`CORE_PERIPHERAL_IRQ_GATE];
  wire ge = core_irq_control[`CORE_GIE];
  wire wake_ev = sleep_i && ovf_ev && run && oe && pe;
  logic [`ST_W-1:0] set_v;
  assign set_v = {wake_ev, cc_ev, ovf_ev};
  logic [`ST_W-1:0] clr_v;
  assign clr_v = wr_stat ? wd[`ST_W-1:0] : '0;
  // Set beats a clear in the same cycle
  logic [`ST_W-1:0] next_status;
  assign next_status = (status & ~clr_v) | set_v;
  wire ovf_req = status[`ST_OVF] && oe;
  wire cc_req = status[`ST_CC] && peripheral_irq_enable_one[`PIE_CC];
  wire next_periph = pe && (ovf_req || cc_req);
  wire next_irq = ge && next_periph;
  // Vector after next instruction is the core's job
  wire next_vec = wake_pend && ge && sleep_i;

  // Read mux
  logic [31:0] rd_val;
  logic rd_hit;
  wire [11:0] ra = s_axi_araddr;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (ra == `OFF_PIE) begin
      rd_val[7:0] = peripheral_irq_enable_one & `PIE_IMPL;
    end else if (ra == `OFF_CTRL) begin
      rd_val[3:0] = second_timer_control;
    end else if (ra == `OFF_TLO) begin
      rd_val[7:0] = count[7:0];
    end else if (ra == `OFF_THI) begin
      rd_val[7:0] = count[15:8];
    end else if (ra == `OFF_CCLO) begin
      rd_val[7:0] = capcmp[7:0];
    end else if (ra == `OFF_CCHI) begin
      rd_val[7:0] = capcmp[15:8];
    end else if (ra == `OFF_CCCTL) begin
      rd_val[1:0] = cc_mode;
    end else if (ra == `OFF_STAT) begin
      rd_val[`ST_W-1:0] = status;
    end else if (ra == `OFF_MASK) begin
      rd_val[`ST_W-1:0] = mask;
    end else if (ra == `OFF_CORE) begin
      rd_val[1:0] = core_irq_control;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      peripheral_irq_enable_one <= 8'h00;
      second_timer_control <= 4'h0;
      core_irq_control <= 2'h0;
      cc_mode <= CC_OFF;
    end else begin
      if (wr_pie) begin
        peripheral_irq_enable_one <= wd[7:0] & `PIE_IMPL;
      end
      if (wr_ctrl) begin
        second_timer_control <= wd[3:0];
      end
      if (wr_core) begin
        core_irq_control <= wd[1:0];
      end
      if (wr_ccctl) begin
        cc_mode <= wd[`CC_MODE_MSB:`CC_MODE_LSB];
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count <= `T_ZERO;
      capcmp <= `T_ZERO;
      status <= '0;
      mask <= '0;
      comp_sync <= 1'b0;
      wake_pend <= 1'b0;
    end else begin
      count <= next_count;
      capcmp <= next_capcmp;
      status <= next_status;
      if (wr_mask) begin
        mask <= wd[`ST_W-1:0];
      end
      comp_sync <= ext_tick_i ? comp_out_i : comp_sync;
      wake_pend <= wake_ev ? 1'b1 : (wake_pend && sleep_i);
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
      periph_irq_o <= 1'b0;
      wake_o <= 1'b0;
      vector_req_o <= 1'b0;
    end else begin
      irq_o <= next_irq || |(next_status & mask);
      periph_irq_o <= next_periph;
      wake_o <= wake_ev;
      vector_req_o <= next_vec;
    end
  end

  // AXI4-Lite handshake
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bus_state <= BUS_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OK;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OK;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      s_axi_arready <= 1'b0;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      s_axi_awready <= (bus_state == BUS_IDLE) && !aw_have &&
        !s_axi_awready;
      s_axi_wready <= (bus_state == BUS_IDLE) && !w_have &&
        !s_axi_wready;
      case (bus_state)
        BUS_IDLE: begin
          if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `RESP_OK : `RESP_ERR;
            bus_state <= BUS_WRESP;
          end else if (rd_go) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? `RESP_OK : `RESP_ERR;
            bus_state <= BUS_RRESP;
          end
        end
        BUS_WRESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            bus_state <= BUS_IDLE;
          end
        end
        BUS_RRESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            bus_state <= BUS_IDLE;
          end
        end
        default: begin
          bus_state <= BUS_IDLE;
        end
      endcase
    end
  end
endmodule

// *** testbench/overflow_checker.sv ***
/*
  Port checker for the timer block.
  Assumes one clock and the active-high asynchronous reset.
*/
`timescale 1ns/1ps
module overflow_checker (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic sleep_i,
  input wire logic irq_o,
  input wire logic periph_irq_o,
  input wire logic wake_o,
  input wire logic vector_req_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  wake_asleep_a: assert property (wake_o |-> $past(sleep_i))
    else $error("wake pulse outside sleep");
  vector_asleep_a: assert property (vector_req_o |-> $past(sleep_i))
    else $error("vector request outside sleep");
  wake_irq_a: assert property (wake_o |-> ##[0:2] periph_irq_o)
    else $error("wake without pending interrupt");
  flag_sticky_a: assert property ($fell(periph_irq_o) |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("peripheral request dropped without a write");
  irq_sticky_a: assert property ($fell(irq_o) |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("interrupt dropped without a write");
  reset_quiet_a: assert property (disable iff (1'b0)
    sys_rst_i |=> !irq_o && !wake_o && !s_axi_bvalid)
    else $error("output active after reset");
  write_answer_a: assert property ($rose(s_axi_awvalid) |->
    ##[1:5] s_axi_bvalid)
    else $error("write not answered");
  read_answer_a: assert property ($rose(s_axi_arvalid) |->
    ##[1:3] s_axi_rvalid)
    else $error("read not answered");
  cover property (wake_o);
  cover property (vector_req_o);
  cover property ($fell(irq_o));
endmodule
bind timer_overflow_event overflow_checker u_chk (.clk_sys_i, .sys_rst_i,
  .s_axi_awvalid, .s_axi_arvalid, .s_axi_bvalid, .s_axi_rvalid, .sleep_i,
  .irq_o, .periph_irq_o, .wake_o, .vector_req_o);

// *** testbench/far_side_model.sv ***
/*
  Far-side model: tick source and core sleep state.
  Assumes the system clock; wake_i is the block's wake pulse.
*/
`timescale 1ns/1ps
module far_side_model (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic tick_en_i,
  input wire logic [1:0] gap_i,
  input wire logic sleep_req_i,
  input wire logic wake_i,
  output logic ext_tick_o,
  output logic sleep_o
);
  logic [1:0] cnt;
  logic [2:0] woke;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt <= 2'h0;
      woke <= 3'h0;
      ext_tick_o <= 1'b0;
      sleep_o <= 1'b0;
    end else begin
      // Strobes on the system clock, so no trigger is missed
      ext_tick_o <= tick_en_i && cnt == 2'h0;
      cnt <= (cnt >= gap_i) ? 2'h0 : cnt + 2'h1;
      // Core stays asleep a few cycles so the vector request shows
      woke <= sleep_req_i ? {woke[1:0], woke[0] | wake_i} : 3'h0;
      sleep_o <= sleep_req_i && !woke[2];
    end
  end
endmodule

// *** testbench/tb_top.sv ***
/*
  Self-checking bench for the timer block.
  Assumes the register map header and the far-side model.
*/
`timescale 1ns/1ps
`include "tmr_map.svh"
module tb_top;
  import tmr_pkg::*;
  logic clk_sys_i = 0, sys_rst_i = 1;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, gap = 0;
  logic comp_out_i = 0, capture_event_i = 0, tick_en = 0, sleep_req = 0;
  logic ext_tick_i, sleep_i, irq_o, periph_irq_o, wake_o, vector_req_o;
  int fails = 0, comparisons = 0, nt = 0, nw = 0, nv = 0;
  timer_overflow_event u_dut (.*);
  far_side_model u_far (.clk_sys_i, .sys_rst_i, .tick_en_i(tick_en),
    .gap_i(gap), .sleep_req_i(sleep_req), .wake_i(wake_o),
    .ext_tick_o(ext_tick_i), .sleep_o(sleep_i));
  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    nt <= nt + ext_tick_i;
    nw <= nw + wake_o;
    nv <= nv + vector_req_o;
    comp_out_i <= 1'($urandom);
  end
  task automatic chk(input string n, input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask
  task automatic rdr(input logic [11:0] a);
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic pair(input logic [11:0] a, output logic [31:0] v);
    v = 0;
    rdr(a);
    v[7:0] = rd[7:0];
    rdr(a + 12'h4);
    v[15:8] = rd[7:0];
  endtask
  task automatic set_t(input logic [15:0] v);
    wr(`OFF_TLO, {24'h0, v[7:0]});
    wr(`OFF_THI, {24'h0, v[15:8]});
  endtask
  // Count is taken from the ticks really seen, overshoot included
  task automatic ticks(input int n, input logic [1:0] g, output int k);
    int b;
    b = nt;
    gap <= g;
    tick_en <= 1;
    while (nt < b + n) @(posedge clk_sys_i);
    tick_en <= 0;
    repeat (6) @(posedge clk_sys_i);
    k = nt - b;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fails++;
    report_and_stop();
  end
  initial begin
    logic [15:0] v;
    logic [31:0] g;
    int k, w0, q0;
    void'($urandom(32'h3b93));
    repeat (10) @(posedge clk_sys_i);
    sys_rst_i <= 0;
    rdr(`OFF_PIE);
    chk("enable reset", rd, 32'h0);
    wr(`OFF_PIE, 32'hff);
    rdr(`OFF_PIE);
    chk("enable bits", rd, 32'h7f);
    rdr(12'hffc);
    chk("unmapped", {30'h0, rs}, 32'h2);
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      v = i == 0 ? `T_MAX - 16'h1 : 16'($urandom);
      set_t(v);
      wr(`OFF_CTRL, 32'h1);
      ticks($urandom_range(20, 1), 2'($urandom), k);
      wr(`OFF_CTRL, 32'h0);
      pair(`OFF_TLO, g);
      chk("count", g, {16'h0, v + 16'(k)});
      rdr(`OFF_STAT);
      chk("flag", {31'h0, rd[0]}, {31'h0, 17'(v) + 17'(k) > 17'hffff});
      wr(`OFF_STAT, 32'h7);
    end
    $display("test count done");
    set_t(`T_MAX);
    wr(`OFF_PIE, 32'h1);
    wr(`OFF_CTRL, 32'h1);
    ticks(1, 2'h0, k);
    for (int c = 0; c < 4; c++) begin
      wr(`OFF_CORE, 32'(c));
      repeat (3) @(posedge clk_sys_i);
      chk("irq", {31'h0, irq_o}, {31'h0, c == 3});
      chk("periph irq", {31'h0, periph_irq_o}, {31'h0, 1'(c)});
    end
    wr(`OFF_STAT, 32'h1);
    repeat (3) @(posedge clk_sys_i);
    chk("irq cleared", {31'h0, irq_o}, 32'h0);
    $display("test interrupt done");
    wr(`OFF_CORE, 32'h0);
    set_t(16'h0010);
    sleep_req <= 1;
    repeat (4) @(posedge clk_sys_i);
    ticks(3, 2'h1, k);
    sleep_req <= 0;
    pair(`OFF_TLO, g);
    chk("sleep hold", g, 32'h10);
    wr(`OFF_CTRL, 32'h3);
    set_t(`T_MAX);
    wr(`OFF_CORE, 32'h3);
    w0 = nw;
    q0 = nv;
    sleep_req <= 1;
    repeat (4) @(posedge clk_sys_i);
    ticks(1, 2'h0, k);
    sleep_req <= 0;
    chk("wake", 32'(nw - w0), 32'h1);
    chk("vector", {31'h0, nv > q0}, 32'h1);
    rdr(`OFF_STAT);
    chk("wake status", rd & 32'h5, 32'h5);
    wr(`OFF_CORE, 32'h0);
    wr(`OFF_STAT, 32'h7);
    $display("test sleep done");
    wr(`OFF_CCCTL, 32'h1);
    v = 16'($urandom);
    set_t(v);
    wr(`OFF_CTRL, 32'h1);
    ticks($urandom_range(9, 1), 2'h2, k);
    wr(`OFF_CTRL, 32'h0);
    capture_event_i <= 1;
    @(posedge clk_sys_i);
    capture_event_i <= 0;
    pair(`OFF_CCLO, g);
    chk("capture", g, {16'h0, v + 16'(k)});
    wr(`OFF_CCLO, 32'h5);
    wr(`OFF_CCHI, 32'h0);
    wr(`OFF_CCCTL, 32'h3);
    set_t(16'h0);
    wr(`OFF_STAT, 32'h7);
    wr(`OFF_CTRL, 32'h1);
    ticks(7, 2'h3, k);
    wr(`OFF_CTRL, 32'h0);
    pair(`OFF_TLO, g);
    chk("period clear", g, 32'(k - 5));
    rdr(`OFF_STAT);
    chk("event flags", rd & 32'h3, 32'h2);
    // Count equals compare value, so the clear is live every cycle
    wr(`OFF_CCLO, 32'h0);
    set_t(16'h0);
    wr(`OFF_TLO, 32'h34);
    pair(`OFF_TLO, g);
    chk("write over clear", g, 32'h34);
    wr(`OFF_MASK, 32'h2);
    repeat (3) @(posedge clk_sys_i);
    chk("masked event irq", {31'h0, irq_o}, 32'h1);
    $display("test compare done");
    report_and_stop();
  end
endmodule
